/* src/mfc_map.vh */
// Purpose: constants for the flow control and address filter block
// Assumes: 40 MHz clock, byte-wide receive stream
// Notes:   all timing counts derive from the clock period
`ifndef MFC_MAP_VH
`define MFC_MAP_VH
`define MFC_CLK_NS        25
`define MFC_SLOT_BITS     512
`define MFC_BIT_NS_100    10
`define MFC_BIT_NS_10     100
`define MFC_SLOT_CYC_100  ((`MFC_SLOT_BITS*`MFC_BIT_NS_100+`MFC_CLK_NS-1)/`MFC_CLK_NS)
`define MFC_SLOT_CYC_10   ((`MFC_SLOT_BITS*`MFC_BIT_NS_10+`MFC_CLK_NS-1)/`MFC_CLK_NS)
`define MFC_MAX_LEN       12'd1518
`define MFC_MAX_LEN_VLAN  12'd1522
`define MFC_PAUSE_DA      48'h0100_00C2_8001
`define MFC_CTRL_TYPE     16'h8808
`define MFC_PAUSE_OP      16'h0001
`define MFC_VLAN_TAG_DEF  16'h8100
`define MFC_THR_FORCE_LO  8'hFF
`define MFC_THR_FORCE_HI  8'h00
`define MFC_CRC_POLY      32'h04C1_1DB7
`define MFC_CRC_INIT      32'hFFFF_FFFF
`define MFC_DA_LAST       11'd5
`define MFC_IDX_TYPE      11'd13
`define MFC_IDX_OP        11'd15
`define MFC_IDX_PARAM     11'd17
`endif

/* src/mfc_addr_filter.v */
// Purpose: destination address capture, hash index and filter decision
// Assumes: first byte of the address arrives first, lsb is first bit
// Notes:   decision is registered one cycle after the sixth address byte
`include "mfc_map.vh"
module mfc_addr_filter (
    input  wire        clk_i,
    input  wire        sys_rst_i,
    input  wire        da_en_i,
    input  wire        da_first_i,
    input  wire        da_last_i,
    input  wire [7:0]  da_byte_i,
    input  wire [47:0] station_addr_i,
    input  wire [63:0] hash_table_i,
    input  wire        pass_all_multicast_i,
    input  wire        promiscuous_enable_i,
    input  wire        inverse_filter_enable_i,
    input  wire        hash_only_enable_i,
    input  wire        hash_perfect_enable_i,
    output wire [47:0] da_o,
    output wire        done_o,
    output wire        pass_o,
    output wire        mcast_o,
    output wire        bcast_o,
    output wire        own_o
);
    reg [31:0] crc_q;
    reg [47:0] da_q;
    reg        done_q;
    reg        pass_q;
    reg        mcast_q;
    reg        bcast_q;
    reg        own_q;
    wire [31:0] crc_d;
    wire [47:0] da_d;
    wire [5:0]  hash_idx;
    wire        hash_hit;
    wire        perfect;
    wire        mc;
    reg         pass_d;

    function [31:0] crc_byte;
        input [31:0] c;
        input [7:0]  d;
        integer      i;
        reg [31:0]   r;
        begin
            r = c;
            for (i = 0; i < 8; i = i + 1) begin
                if (r[31] ^ d[i])
                    r = {r[30:0], 1'b0} ^ `MFC_CRC_POLY;
                else
                    r = {r[30:0], 1'b0};
            end
            crc_byte = r;
        end
    endfunction

    assign crc_d    = crc_byte(da_first_i ? `MFC_CRC_INIT : crc_q, da_byte_i);
    assign da_d     = {da_byte_i, da_q[47:8]};
    assign hash_idx = crc_d[31:26];
    assign hash_hit = hash_table_i[hash_idx];
    assign perfect  = (da_d == station_addr_i);
    assign mc       = da_d[0];

    always @* begin
        if (promiscuous_enable_i && !inverse_filter_enable_i)
            pass_d = 1'b1;
        else if (inverse_filter_enable_i)
            pass_d = !perfect;
        else if (pass_all_multicast_i && mc)
            pass_d = 1'b1;
        else if (hash_only_enable_i && hash_perfect_enable_i)
            pass_d = hash_hit;
        else if (hash_perfect_enable_i)
            pass_d = mc ? hash_hit : perfect;
        else
            pass_d = perfect;
    end

    always @(posedge clk_i) begin
        if (sys_rst_i) begin
            crc_q   <= `MFC_CRC_INIT;
            da_q    <= 48'h0000_0000_0000;
            done_q  <= 1'b0;
            pass_q  <= 1'b0;
            mcast_q <= 1'b0;
            bcast_q <= 1'b0;
            own_q   <= 1'b0;
        end else begin
            done_q <= 1'b0;
            if (da_en_i) begin
                crc_q <= crc_d;
                da_q  <= da_d;
                if (da_last_i) begin
                    done_q  <= 1'b1;
                    pass_q  <= pass_d;
                    mcast_q <= mc;
                    bcast_q <= &da_d;
                    own_q   <= perfect;
                end
            end
        end
    end

    assign da_o    = da_q;
    assign done_o  = done_q;
    assign pass_o  = pass_q;
    assign mcast_o = mcast_q;
    assign bcast_o = bcast_q;
    assign own_o   = own_q;
endmodule // mfc_addr_filter

/* src/mfc_flow_ctrl.v */
// Purpose: pause decode, automatic pause, back pressure, vlan and filtering
// Assumes: receive bytes, fifo level and tx status are on clk_i
// Notes:   received pause frames are obeyed regardless of the enable
`include "mfc_map.vh"
module mfc_flow_ctrl #(
    parameter LVL_W = 8,
    parameter DUR_W = 4
) (
    input  wire             clk_i,
    input  wire             sys_rst_i,
    input  wire             pause_backpressure_enable_i,
    input  wire             full_duplex_i,
    input  wire             speed_100_i,
    input  wire [LVL_W-1:0] rx_fifo_level_i,
    input  wire [LVL_W-1:0] fifo_high_threshold_i,
    input  wire [LVL_W-1:0] fifo_low_threshold_i,
    input  wire [15:0]      transmit_pause_time_i,
    input  wire [DUR_W-1:0] backpressure_duration_i,
    input  wire             backpressure_any_frame_i,
    input  wire             backpressure_own_address_i,
    input  wire             backpressure_multicast_i,
    input  wire             backpressure_broadcast_i,
    input  wire             pass_all_multicast_i,
    input  wire             promiscuous_enable_i,
    input  wire             inverse_filter_enable_i,
    input  wire             hash_only_enable_i,
    input  wire             hash_perfect_enable_i,
    input  wire [47:0]      station_addr_i,
    input  wire [63:0]      hash_table_i,
    input  wire [15:0]      vlan_tag_a_i,
    input  wire [15:0]      vlan_tag_b_i,
    input  wire             rx_valid_i,
    input  wire             rx_sof_i,
    input  wire             rx_eof_i,
    input  wire [7:0]       rx_data_i,
    input  wire             tx_busy_i,
    input  wire             tx_pause_ack_i,
    input  wire [10:0]      tx_frame_len_i,
    input  wire [15:0]      tx_frame_type_i,
    output wire             rx_frame_done_o,
    output wire             rx_frame_accept_o,
    output wire             rx_frame_vlan_o,
    output wire             rx_frame_too_long_o,
    output wire             rx_ctrl_frame_o,
    output wire             rx_pause_rcvd_o,
    output wire             tx_hold_o,
    output wire             tx_pause_req_o,
    output wire [15:0]      tx_pause_time_o,
    output wire             tx_len_ok_o,
    output wire             jam_o
);
    localparam [1:0] AP_IDLE = 2'd0;
    localparam [1:0] AP_ON   = 2'd1;
    localparam [1:0] AP_HELD = 2'd2;
    localparam [1:0] AP_OFF  = 2'd3;
    localparam [1:0] BP_IDLE = 2'd0;
    localparam [1:0] BP_RUN  = 2'd1;
    localparam [1:0] BP_ONE  = 2'd2;
    localparam [11:0] SLOT_100 = `MFC_SLOT_CYC_100;
    localparam [11:0] SLOT_10  = `MFC_SLOT_CYC_10;

    reg  [10:0]      cnt_q;
    reg  [15:0]      w16_q;
    reg              vlan_q;
    reg              ctrl_q;
    reg              pop_q;
    reg  [15:0]      param_q;
    reg              busy_sof_q;
    reg              done_q;
    reg              accept_q;
    reg              fvlan_q;
    reg              long_q;
    reg              fctrl_q;
    reg              prcv_q;
    reg              pend_q;
    reg  [15:0]      pend_time_q;
    reg  [15:0]      pause_cnt_q;
    reg  [11:0]      slot_cnt_q;
    reg  [1:0]       ap_q;
    reg  [15:0]      ap_time_q;
    reg  [1:0]       bp_q;
    reg  [DUR_W-1:0] bp_tmr_q;
    reg              one_seen_q;
    reg              jam_q;
    reg              tx_ok_q;

    wire [10:0] idx;
    wire [15:0] w16_d;
    wire [11:0] len;
    wire [11:0] rx_max;
    wire [11:0] tx_max;
    wire        byte_eof;
    wire        too_long;
    wire        is_pause;
    wire        tag_hit;
    wire        tx_tag;
    wire [11:0] slot_len;
    wire        slot_tick;
    wire        apply;
    wire        forced;
    wire        high_hit;
    wire        low_hit;
    wire        en_fd;
    wire        en_hd;
    wire        class_hit;
    wire [47:0] da;
    wire        flt_done;
    wire        flt_pass;
    wire        flt_mc;
    wire        flt_bc;
    wire        flt_own;

    assign idx      = rx_sof_i ? 11'd0 : cnt_q;
    assign w16_d    = {w16_q[7:0], rx_data_i};
    assign byte_eof = rx_valid_i && rx_eof_i;
    assign len      = {1'b0, idx} + 12'd1;
    assign tag_hit  = (w16_d == vlan_tag_a_i) || (w16_d == vlan_tag_b_i);
    assign tx_tag   = (tx_frame_type_i == vlan_tag_a_i) || (tx_frame_type_i == vlan_tag_b_i);
    assign rx_max   = vlan_q ? `MFC_MAX_LEN_VLAN : `MFC_MAX_LEN;
    assign tx_max   = tx_tag ? `MFC_MAX_LEN_VLAN : `MFC_MAX_LEN;
    assign too_long = len > rx_max;
    assign is_pause = ctrl_q && pop_q && (da == `MFC_PAUSE_DA) && (idx >= `MFC_IDX_PARAM);

    // a forced high level must also hide the low level, else it would cancel
    assign forced   = (fifo_low_threshold_i == `MFC_THR_FORCE_LO) &&
                      (fifo_high_threshold_i == `MFC_THR_FORCE_HI);
    assign high_hit = forced || (rx_fifo_level_i >= fifo_high_threshold_i);
    assign low_hit  = !forced && (rx_fifo_level_i < fifo_low_threshold_i);
    assign en_fd    = pause_backpressure_enable_i && full_duplex_i;
    assign en_hd    = pause_backpressure_enable_i && !full_duplex_i;

    assign slot_len  = speed_100_i ? SLOT_100 : SLOT_10;
    assign slot_tick = (slot_cnt_q == slot_len - 12'd1);
    assign apply     = pend_q && !tx_busy_i;

    assign class_hit = backpressure_any_frame_i ||
                       (backpressure_own_address_i && flt_own) ||
                       (backpressure_multicast_i && flt_mc && !flt_bc) ||
                       (backpressure_broadcast_i && flt_bc);

    mfc_addr_filter u_filter (
        .clk_i                   (clk_i),
        .sys_rst_i               (sys_rst_i),
        .da_en_i                 (rx_valid_i && (idx <= `MFC_DA_LAST)),
        .da_first_i              (rx_sof_i),
        .da_last_i               (idx == `MFC_DA_LAST),
        .da_byte_i               (rx_data_i),
        .station_addr_i          (station_addr_i),
        .hash_table_i            (hash_table_i),
        .pass_all_multicast_i    (pass_all_multicast_i),
        .promiscuous_enable_i    (promiscuous_enable_i),
        .inverse_filter_enable_i (inverse_filter_enable_i),
        .hash_only_enable_i      (hash_only_enable_i),
        .hash_perfect_enable_i   (hash_perfect_enable_i),
        .da_o                    (da),
        .done_o                  (flt_done),
        .pass_o                  (flt_pass),
        .mcast_o                 (flt_mc),
        .bcast_o                 (flt_bc),
        .own_o                   (flt_own)
    );

    // receive byte parse and end-of-frame verdict
    always @(posedge clk_i) begin
        if (sys_rst_i) begin
            cnt_q      <= 11'd0;
            w16_q      <= 16'h0000;
            vlan_q     <= 1'b0;
            ctrl_q     <= 1'b0;
            pop_q      <= 1'b0;
            param_q    <= 16'h0000;
            busy_sof_q <= 1'b0;
            done_q     <= 1'b0;
            accept_q   <= 1'b0;
            fvlan_q    <= 1'b0;
            long_q     <= 1'b0;
            fctrl_q    <= 1'b0;
            prcv_q     <= 1'b0;
        end else begin
            done_q <= 1'b0;
            prcv_q <= 1'b0;
            if (rx_valid_i) begin
                w16_q <= w16_d;
                // count saturates so very long frames stay flagged
                if (idx != 11'h7FF)
                    cnt_q <= idx + 11'd1;
                if (rx_sof_i) begin
                    vlan_q     <= 1'b0;
                    ctrl_q     <= 1'b0;
                    pop_q      <= 1'b0;
                    busy_sof_q <= tx_busy_i;
                end
                if (idx == `MFC_IDX_TYPE) begin
                    vlan_q <= tag_hit;
                    ctrl_q <= (w16_d == `MFC_CTRL_TYPE);
                end
                if (idx == `MFC_IDX_OP)
                    pop_q <= ctrl_q && (w16_d == `MFC_PAUSE_OP);
                if (idx == `MFC_IDX_PARAM)
                    param_q <= w16_d;
                if (rx_eof_i) begin
                    done_q   <= 1'b1;
                    fvlan_q  <= vlan_q;
                    long_q   <= too_long;
                    fctrl_q  <= ctrl_q;
                    accept_q <= (flt_pass || ctrl_q) && !too_long;
                    prcv_q   <= is_pause && !too_long;
                end
            end
        end
    end

    // received pause hold-off
    always @(posedge clk_i) begin
        if (sys_rst_i) begin
            pend_q      <= 1'b0;
            pend_time_q <= 16'h0000;
            pause_cnt_q <= 16'h0000;
            slot_cnt_q  <= 12'd0;
        end else begin
            if (byte_eof && is_pause && !too_long) begin
                pend_q      <= 1'b1;
                pend_time_q <= param_q;
            end else if (apply) begin
                pend_q <= 1'b0;
            end
            if (apply || slot_tick)
                slot_cnt_q <= 12'd0;
            else
                slot_cnt_q <= slot_cnt_q + 12'd1;
            if (apply)
                pause_cnt_q <= pend_time_q;
            else if (slot_tick && (pause_cnt_q != 16'h0000))
                pause_cnt_q <= pause_cnt_q - 16'h0001;
        end
    end

    // automatic pause transmit, full duplex
    always @(posedge clk_i) begin
        if (sys_rst_i) begin
            ap_q      <= AP_IDLE;
            ap_time_q <= 16'h0000;
        end else begin
            case (ap_q)
                AP_IDLE: begin
                    if (en_fd && high_hit) begin
                        ap_q      <= AP_ON;
                        ap_time_q <= transmit_pause_time_i;
                    end
                end
                AP_ON: begin
                    if (tx_pause_ack_i)
                        ap_q <= AP_HELD;
                end
                AP_HELD: begin
                    // while enabled, re-arm only through low, so level jitter cannot flood the link
                    if (!en_fd)
                        ap_q <= AP_IDLE;
                    else if (low_hit) begin
                        ap_q      <= AP_OFF;
                        ap_time_q <= 16'h0000;
                    end
                end
                AP_OFF: begin
                    if (tx_pause_ack_i)
                        ap_q <= AP_IDLE;
                end
                default: ap_q <= AP_IDLE;
            endcase
        end
    end

    // back pressure, half duplex
    always @(posedge clk_i) begin
        if (sys_rst_i) begin
            bp_q       <= BP_IDLE;
            bp_tmr_q   <= {DUR_W{1'b0}};
            one_seen_q <= 1'b0;
        end else begin
            case (bp_q)
                BP_IDLE: begin
                    bp_tmr_q <= {DUR_W{1'b0}};
                    if (en_hd && high_hit)
                        bp_q <= BP_RUN;
                end
                BP_RUN: begin
                    one_seen_q <= 1'b0;
                    if (!en_hd || low_hit) begin
                        bp_q     <= BP_IDLE;
                        bp_tmr_q <= {DUR_W{1'b0}};
                    end else if (bp_tmr_q >= backpressure_duration_i)
                        bp_q <= BP_ONE;
                    else if (slot_tick)
                        bp_tmr_q <= bp_tmr_q + {{(DUR_W-1){1'b0}}, 1'b1};
                end
                BP_ONE: begin
                    if (!en_hd)
                        bp_q <= BP_IDLE;
                    else if (rx_valid_i && rx_sof_i)
                        one_seen_q <= 1'b1;
                    else if (byte_eof && one_seen_q) begin
                        bp_tmr_q <= {DUR_W{1'b0}};
                        bp_q     <= low_hit ? BP_IDLE : BP_RUN;
                    end
                end
                default: bp_q <= BP_IDLE;
            endcase
        end
    end

    // jam starts at the address decision of a new frame and lasts to its end
    always @(posedge clk_i) begin
        if (sys_rst_i) begin
            jam_q <= 1'b0;
        end else if (byte_eof) begin
            jam_q <= 1'b0;
        end else if (flt_done && (bp_q == BP_RUN) && class_hit && !busy_sof_q) begin
            jam_q <= 1'b1;
        end
    end

    always @(posedge clk_i) begin
        if (sys_rst_i)
            tx_ok_q <= 1'b0;
        else
            tx_ok_q <= ({1'b0, tx_frame_len_i} <= tx_max);
    end

    assign rx_frame_done_o     = done_q;
    assign rx_frame_accept_o   = accept_q;
    assign rx_frame_vlan_o     = fvlan_q;
    assign rx_frame_too_long_o = long_q;
    assign rx_ctrl_frame_o     = fctrl_q;
    assign rx_pause_rcvd_o     = prcv_q;
    assign tx_hold_o           = (pause_cnt_q != 16'h0000);
    assign tx_pause_req_o      = (ap_q == AP_ON) || (ap_q == AP_OFF);
    assign tx_pause_time_o     = ap_time_q;
    assign tx_len_ok_o         = tx_ok_q;
    assign jam_o               = jam_q;
endmodule // mfc_flow_ctrl

/* bench/mfc_flow_ctrl_sva.sv */
// Purpose: port checks for mfc_flow_ctrl
// Assumes: one clock, sync reset
// Notes:   bound from the bench top
module mfc_flow_ctrl_sva (
    input logic        clk_i, sys_rst_i, rx_valid_i, rx_eof_i, full_duplex_i, pause_backpressure_enable_i,
    input logic        tx_pause_ack_i, rx_frame_done_o, rx_frame_accept_o, rx_frame_too_long_o, rx_ctrl_frame_o,
    input logic        rx_pause_rcvd_o, tx_pause_req_o, tx_hold_o, jam_o,
    input logic [15:0] tx_pause_time_o, transmit_pause_time_i
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge clk_i); endclocking
    default disable iff (sys_rst_i);
    a_done_after_eof: assert property (rx_valid_i && rx_eof_i |=> rx_frame_done_o)
        else $error("no done");
    a_done_cause: assert property (rx_frame_done_o |-> $past(rx_valid_i && rx_eof_i))
        else $error("stray done");
    a_pause_valid: assert property (rx_pause_rcvd_o |-> rx_frame_done_o && !rx_frame_too_long_o)
        else $error("bad pause");
    a_ctrl_forward: assert property (rx_frame_done_o && rx_ctrl_frame_o && !rx_frame_too_long_o |-> rx_frame_accept_o)
        else $error("ctrl dropped");
    a_long_dropped: assert property (rx_frame_done_o && rx_frame_too_long_o |-> !rx_frame_accept_o)
        else $error("long kept");
    a_req_held: assert property (tx_pause_req_o && !tx_pause_ack_i && pause_backpressure_enable_i |=>
        tx_pause_req_o && $stable(tx_pause_time_o)) else $error("req lost");
    a_req_time: assert property ($rose(tx_pause_req_o) |-> tx_pause_time_o == 16'h0000 ||
        tx_pause_time_o == $past(transmit_pause_time_i)) else $error("bad time");
    a_req_ack: assert property (tx_pause_ack_i |=> !tx_pause_req_o) else $error("req after ack");
    a_jam_mode: assert property ($rose(jam_o) |-> !full_duplex_i && pause_backpressure_enable_i)
        else $error("jam in wrong mode");
    a_jam_eof: assert property (jam_o && rx_valid_i && rx_eof_i |=> !jam_o) else $error("jam past eof");
    c_pause: cover property (rx_pause_rcvd_o);
    c_hold: cover property ($rose(tx_hold_o));
    c_jam: cover property ($rose(jam_o));
endmodule // mfc_flow_ctrl_sva

/* bench/mfc_station.sv */
// Purpose: remote station sending frames and taking pause requests
// Assumes: bytes change at falling edge
// Notes:   data line shows inverse of last byte when idle, never a stale value
module mfc_station (
    input  logic       clk_i,
    input  logic       tx_pause_req_i,
    output logic       rx_valid_o, rx_sof_o, rx_eof_o, tx_pause_ack_o,
    output logic [7:0] rx_data_o
);
    timeunit 1ns;
    timeprecision 1ps;
    int wait_n = 0;
    initial {rx_valid_o, rx_sof_o, rx_eof_o, tx_pause_ack_o, rx_data_o} = '0;
    // slow taker: ack only after the request has stood a while
    always @(negedge clk_i) begin
        tx_pause_ack_o <= tx_pause_req_i && wait_n == 3;
        wait_n <= (tx_pause_req_i && wait_n < 3) ? wait_n + 1 : 0;
    end
    task automatic send(input logic [7:0] f[$]);
        foreach (f[i]) begin
            @(negedge clk_i);
            {rx_valid_o, rx_sof_o, rx_eof_o, rx_data_o} = {1'b1, i == 0, i == f.size() - 1, f[i]};
        end
        @(negedge clk_i);
        {rx_valid_o, rx_sof_o, rx_eof_o, rx_data_o} = {3'b000, ~rx_data_o};
    endtask
endmodule // mfc_station

/* bench/mfc_flow_ctrl_tb_top.sv */
// Purpose: self-checking bench for mfc_flow_ctrl
// Assumes: 40 MHz clock, inputs driven at falling edge
// Notes:   frame verdicts queued by the driver, checked at done
module mfc_flow_ctrl_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_i = 0, sys_rst_i = 1, pause_backpressure_enable_i = 0, full_duplex_i = 1, speed_100_i = 1, tx_busy_i = 0;
    logic backpressure_any_frame_i = 0, backpressure_own_address_i = 0, backpressure_multicast_i = 0;
    logic backpressure_broadcast_i = 0, jam_seen = 0, hall, ex;
    logic pass_all_multicast_i, promiscuous_enable_i, inverse_filter_enable_i, hash_only_enable_i, hash_perfect_enable_i;
    logic [7:0] rx_fifo_level_i = 0, fifo_high_threshold_i = 8'h80, fifo_low_threshold_i = 8'h10, rx_data_i;
    logic [15:0] transmit_pause_time_i = 16'h0012, vlan_tag_a_i = 16'h8100, vlan_tag_b_i = 16'h9100, tx_frame_type_i;
    logic [15:0] tx_pause_time_o;
    logic [3:0] backpressure_duration_i = 4'h2;
    logic [10:0] tx_frame_len_i;
    logic [47:0] station_addr_i = 48'h5544_3322_1100;
    logic [63:0] hash_table_i = 0;
    logic rx_valid_i, rx_sof_i, rx_eof_i, tx_pause_ack_i, rx_frame_done_o, rx_frame_accept_o, rx_frame_vlan_o;
    logic rx_frame_too_long_o, rx_ctrl_frame_o, rx_pause_rcvd_o, tx_hold_o, tx_pause_req_o, tx_len_ok_o, jam_o;
    logic [4:0] md = 0;
    logic [1:0] sel;
    logic [47:0] da_v;
    logic [31:0] rnd;
    logic len_exp, len_chk = 0;
    // accept, too long, pause, vlan, control, jam seen
    logic [5:0] exp_q[$];
    // mode, hash hit, address kind (0 own, 1 other, 2 multicast), pass
    logic [8:0] tbl[9] = '{9'b01000_0_01_1, 9'b00100_0_00_0, 9'b00100_0_01_1, 9'b10000_0_10_1, 9'b00011_1_01_1,
                           9'b00011_0_01_0, 9'b00001_1_01_0, 9'b00001_1_10_1, 9'b00000_1_10_0};
    int errors = 0, tests_run = 0, cyc = 0, seed = 19322;
    assign {pass_all_multicast_i, promiscuous_enable_i, inverse_filter_enable_i, hash_only_enable_i,
            hash_perfect_enable_i} = md;
    always #12.5 clk_i = ~clk_i;
    mfc_flow_ctrl i_mfc_flow_ctrl (.*);
    mfc_station i_mfc_station (.clk_i(clk_i), .tx_pause_req_i(tx_pause_req_o), .rx_valid_o(rx_valid_i),
        .rx_sof_o(rx_sof_i), .rx_eof_o(rx_eof_i), .tx_pause_ack_o(tx_pause_ack_i), .rx_data_o(rx_data_i));
    task automatic cmp(input logic [15:0] got, input logic [15:0] want);
        tests_run++;
        if (got !== want) begin
            errors++;
            $display("[ERR] %0t got %h exp %h", $time, got, want);
        end
    endtask
    task automatic cmp_frame(input logic [5:0] got, input logic [5:0] want);
        cmp(16'(got), 16'(want));
    endtask
    task automatic cmp_len(input logic got, input logic want);
        cmp(16'(got), 16'(want));
    endtask
    // hash index from the destination, bytes in wire order, lsb first
    function automatic logic [5:0] hidx(input logic [47:0] a);
        logic [31:0] c = 32'hFFFF_FFFF;
        for (int i = 0; i < 48; i++)
            c = (c[31] ^ a[i]) ? ({c[30:0], 1'b0} ^ 32'h04C1_1DB7) : {c[30:0], 1'b0};
        return c[31:26];
    endfunction
    task end_of_test;
        errors += exp_q.size();
        $display("errors=%0d tests_run=%0d", errors, tests_run);
        if (errors == 0 && tests_run > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    // bytes 14..17 carry pause opcode 1 and parameter 1; source and payload random
    task automatic fr(input logic [47:0] da, input logic [15:0] ty, input int len, input logic [5:0] e);
        logic [7:0] f[$];
        for (int i = 0; i < len; i++)
            f.push_back(i < 6 ? da[8*i+:8] : i == 12 ? ty[15:8] : i == 13 ? ty[7:0] :
                        (i > 13 && i < 18) ? 8'(i & 1) : 8'($random(seed)));
        exp_q.push_back(e);
        i_mfc_station.send(f);
    endtask
    task automatic wreq(input logic v);
        for (int k = 0; k < 60 && tx_pause_req_o !== v; k++) @(negedge clk_i);
        cmp(tx_pause_req_o, v);
    endtask
    always @(negedge clk_i) begin
        cyc++;
        if (len_chk) cmp_len(tx_len_ok_o, len_exp);
        // lengths around both limits, half of the types tagged
        rnd = $random(seed);
        tx_frame_len_i = 11'd1504 + 11'(rnd[4:0]);
        tx_frame_type_i = rnd[5] ? vlan_tag_b_i : rnd[31:16];
        len_exp = (tx_frame_len_i <= ((tx_frame_type_i == vlan_tag_a_i || tx_frame_type_i == vlan_tag_b_i) ?
                                      11'd1522 : 11'd1518));
        len_chk = !sys_rst_i;
        jam_seen |= (jam_o === 1'b1);
        if (rx_frame_done_o === 1'b1) begin
            cmp_frame({rx_frame_accept_o, rx_frame_too_long_o, rx_pause_rcvd_o, rx_frame_vlan_o, rx_ctrl_frame_o,
                       jam_seen}, exp_q.pop_front());
            jam_seen = 0;
        end
        if (cyc > 20000) begin
            errors++;
            end_of_test();
        end
    end
    initial begin
        repeat (4) @(negedge clk_i);
        sys_rst_i = 0;
        fr(station_addr_i, 16'h0800, 64, 6'b100_000);
        fr(48'h0000_0000_0200, 16'h0800, 64, 6'b000_000);
        tx_busy_i = 1; // hold-off must wait for the frame in flight
        fr(48'h0100_00C2_8001, 16'h8808, 64, 6'b101_010);
        repeat (3) @(negedge clk_i);
        cmp(tx_hold_o, 0);
        tx_busy_i = 0;
        repeat (3) @(negedge clk_i);
        cmp(tx_hold_o, 1);
        // one slot at 100 Mbps is 205 cycles from the load
        repeat (202) @(negedge clk_i);
        cmp(tx_hold_o, 1);
        @(negedge clk_i);
        cmp(tx_hold_o, 0);
        fr(station_addr_i, 16'h0800, 1519, 6'b010_000);
        fr(station_addr_i, 16'h8100, 1522, 6'b100_100);
        fr(station_addr_i, 16'h9100, 1523, 6'b010_100);
        foreach (tbl[k]) begin
            {md, hall, sel, ex} = tbl[k];
            da_v = sel == 2'b00 ? station_addr_i : 48'h0000_0000_0200 | 48'(sel[1]);
            // only the indexed bit decides, so a wrong index is caught
            hash_table_i = hall ? 64'h1 << hidx(da_v) : ~(64'h1 << hidx(da_v));
            fr(da_v, 16'h0800, 64, {ex, 5'b00000});
        end
        md = 0;
        pause_backpressure_enable_i = 1;
        rx_fifo_level_i = 8'h90;
        wreq(1);
        cmp(tx_pause_time_o, transmit_pause_time_i);
        wreq(0);
        repeat (20) @(negedge clk_i);
        cmp(tx_pause_req_o, 0);
        rx_fifo_level_i = 8'h0F;
        wreq(1);
        cmp(tx_pause_time_o, 0);
        wreq(0);
        full_duplex_i = 0; // forced thresholds: back pressure on enabled frames except the one let through after the timer and one started while tx busy
        {fifo_low_threshold_i, fifo_high_threshold_i, backpressure_any_frame_i} = {8'hFF, 8'h00, 1'b1};
        fr(station_addr_i, 16'h0800, 64, 6'b100_001);
        // wait out two slots so the timer has expired
        repeat (420) @(negedge clk_i);
        fr(station_addr_i, 16'h0800, 64, 6'b100_000);
        fr(station_addr_i, 16'h0800, 64, 6'b100_001);
        tx_busy_i = 1;
        fr(station_addr_i, 16'h0800, 64, 6'b100_000);
        tx_busy_i = 0;
        {fifo_low_threshold_i, fifo_high_threshold_i} = {8'h10, 8'h80};
        fr(station_addr_i, 16'h0800, 64, 6'b100_000);
        repeat (5) @(negedge clk_i);
        end_of_test();
    end
endmodule // mfc_flow_ctrl_tb_top
bind mfc_flow_ctrl mfc_flow_ctrl_sva i_mfc_flow_ctrl_sva (.*);
